// ### bench/sser_host.sv
// host apb master model: one transfer at a time, request held until pready or for up to 20 extra wait cycles
`timescale 1ns/1ns
module sser_host (
	// clock
	input wire logic i_clock,
	// apb request
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata,
	// apb answer
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	input wire logic i_pslverr
);
	// ============================================================
	// idle bus at time zero
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0000_0000;
	end

	// one transfer; released lines show the inverse so a stale address never matches
	task automatic xfer(input logic wr, input logic [7:0] addr, output logic [31:0] data,
		output logic err, output logic ok);
		int n;
		n = 0;
		@(posedge i_clock);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= wr;
		o_paddr <= addr;
		o_pwdata <= 32'hA5A5_5A5A;
		@(posedge i_clock);
		o_penable <= 1'b1;
		@(posedge i_clock);
		// bounded wait so a dead slave cannot hang the run
		while (i_pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge i_clock);
		end
		ok = (i_pready === 1'b1);
		data = i_prdata;
		err = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_paddr <= ~addr;
		o_pwdata <= 32'h5A5A_A5A5;
	endtask
endmodule // sser_host

// ### bench/tb_sser_regs.sv
// self-checking bench for the status and error register bank
`timescale 1ns/1ns
module tb_sser_regs
	import sser_pkg::*;
	();
	// ============================================================
	// design pins
	logic clock, rst_n, psel, penable, pwrite, pslverr, pready, cmd_ready;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic soft_rst, boot_fail, cmd_fail, cfg_bad, discard, aux_err;
	logic cmd_busy, man_busy, acc_new, aux_new;
	logic [15:0] ax, ay, az, ar;
	logic [63:0] samp;
	int n_fail;
	int cmp_count;

	sser_regs #(.ADDR_W(8), .PART_ID(8'h5C)) DUT (
		.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_soft_reset(soft_rst),
		.i_boot_fail(boot_fail), .i_cmd_fail(cmd_fail),
		.i_accel_config_register_invalid(cfg_bad), .i_buffer_discard(discard),
		.i_aux_master_error(aux_err), .i_cmd_busy(cmd_busy),
		.i_secondary_manual_busy(man_busy), .i_accel_sample_new(acc_new),
		.i_aux_sample_new(aux_new), .i_aux_x(ax), .i_aux_y(ay), .i_aux_z(az),
		.i_aux_r(ar), .o_cmd_ready(cmd_ready));

	sser_host host (
		.i_clock(clock), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
		.o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
		.i_pslverr(pslverr));

	// 250 MHz clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ============================================================
	// compare, verdict and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one transfer by byte address; a lost answer ends the run
	task automatic go(input logic wr, input logic [7:0] addr, input logic [31:0] exp,
		input logic eerr);
		logic [31:0] d;
		logic e, ok;
		host.xfer(wr, addr, d, e, ok);
		if (!ok) begin
			n_fail++;
			stop_test();
		end else begin
			if (!wr) chk(d, exp);
			chk({31'h0, e}, {31'h0, eerr});
		end
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		go(1'b0, {idx[5:0], 2'b00}, exp, 1'b0);
	endtask

	// ============================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		{soft_rst, boot_fail, cmd_fail, cfg_bad, discard, aux_err} = 6'h00;
		{cmd_busy, man_busy, acc_new, aux_new} = 4'h0;
		ax = 16'h1234;
		ay = 16'h5678;
		az = 16'h9ABC;
		ar = 16'hDEF0;
		samp = {ar, az, ay, ax};
		n_fail = 0;
		cmp_count = 0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		// reset values
		rd(SSER_IDX_PART_ID, 32'h0000_005C);
		rd(SSER_IDX_ERROR, {24'h0, SSER_ERROR_RESET});
		rd(SSER_IDX_STATUS, {24'h0, SSER_STATUS_RESET});
		chk({31'h0, cmd_ready}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			rd(8'(SSER_IDX_AUX_X_LO + i), 32'h0);
		end
		// writes ignored, holes and misaligned addresses refused
		go(1'b1, 8'h00, 32'h0, 1'b0);
		go(1'b1, 8'h0C, 32'h0, 1'b0);
		rd(SSER_IDX_PART_ID, 32'h0000_005C);
		rd(SSER_IDX_STATUS, 32'h0000_0010);
		go(1'b0, 8'h04, 32'h0, 1'b1);
		go(1'b0, 8'h0D, 32'h0, 1'b1);
		// every error source at once, then read-clear and soft reset
		@(posedge clock);
		{boot_fail, cmd_fail, discard, aux_err, cfg_bad} <= 5'h1F;
		@(posedge clock);
		{boot_fail, cmd_fail, discard, aux_err} <= 4'h0;
		rd(SSER_IDX_ERROR, 32'h0000_00C7);
		rd(SSER_IDX_ERROR, 32'h0000_0005);
		cfg_bad <= 1'b0;
		rd(SSER_IDX_ERROR, 32'h0000_0001);
		soft_rst <= 1'b1;
		@(posedge clock);
		soft_rst <= 1'b0;
		rd(SSER_IDX_ERROR, 32'h0000_0000);
		// status sources; a command only starts while the decoder is ready
		if (cmd_ready === 1'b1) cmd_busy <= 1'b1;
		man_busy <= 1'b1;
		acc_new <= 1'b1;
		aux_new <= 1'b1;
		@(posedge clock);
		{acc_new, aux_new} <= 2'b00;
		rd(SSER_IDX_STATUS, 32'h0000_00A4);
		chk({31'h0, cmd_ready}, 32'h0);
		rd(SSER_IDX_AUX_X_LO, {24'h0, ax[7:0]});
		rd(SSER_IDX_STATUS, 32'h0000_0084);
		for (int i = 1; i < 8; i++) begin
			rd(8'(SSER_IDX_AUX_X_LO + i), {24'h0, samp[i*8 +: 8]});
		end
		rd(SSER_IDX_ACC_FIRST, 32'h0);
		rd(SSER_IDX_STATUS, 32'h0000_0004);
		{cmd_busy, man_busy} <= 2'b00;
		rd(SSER_IDX_STATUS, 32'h0000_0010);
		chk({31'h0, cmd_ready}, 32'h1);
		// power-on reset mid-run is the other way out of a fatal error
		boot_fail <= 1'b1;
		@(posedge clock);
		boot_fail <= 1'b0;
		rd(SSER_IDX_ERROR, 32'h0000_0001);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd(SSER_IDX_ERROR, {24'h0, SSER_ERROR_RESET});
		rd(SSER_IDX_STATUS, {24'h0, SSER_STATUS_RESET});
		chk({31'h0, cmd_ready}, 32'h1);
		stop_test();
	end
endmodule // tb_sser_regs

// ### hw/sser_aux_hold.sv
// auxiliary sample store: x, y, z and resistance words held in flip-flops
`timescale 1ns/1ns
module sser_aux_hold
	import sser_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int CHANNELS = 4
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// new sample set
	input wire logic i_load,
	input wire logic [CHANNELS-1:0][SAMPLE_W-1:0] i_sample,
	// stored samples
	output logic [CHANNELS-1:0][SAMPLE_W-1:0] o_sample
);

	// ============================================================
	// elaboration check
	if (SAMPLE_W != 16) begin : g_bad_sample_w
		$error("sser_aux_hold: byte pairs need 16-bit samples");
	end
	if (CHANNELS < 1) begin : g_bad_channels
		$error("sser_aux_hold: CHANNELS must be at least 1");
	end

	// ============================================================
	// all channels load together so one set never mixes two samples
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int ch = 0; ch < CHANNELS; ch++) begin
				o_sample[ch] <= SSER_AUX_RESET;
			end
		end else if (i_load) begin
			for (int ch = 0; ch < CHANNELS; ch++) begin
				o_sample[ch] <= i_sample[ch];
			end
		end
	end

endmodule // sser_aux_hold

// ### hw/sser_flag.sv
// sticky flag bank: hardware set wins over a clear in the same cycle
`timescale 1ns/1ns
module sser_flag
	import sser_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// set and clear strobes
	input wire logic [WIDTH-1:0] i_set,
	input wire logic [WIDTH-1:0] i_clear,
	// flag state
	output logic [WIDTH-1:0] o_flag
);

	// ============================================================
	// elaboration check
	if (WIDTH < 1) begin : g_bad_width
		$error("sser_flag: WIDTH must be at least 1");
	end

	// ============================================================
	// a set arriving in the clear cycle survives, so no event is lost
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_flag <= '0;
		end else begin
			o_flag <= (o_flag & ~i_clear) | i_set;
		end
	end

endmodule // sser_flag

// ### hw/sser_pkg.sv
// package: register indices, field positions and reset values of the status bank
package sser_pkg;

	// ============================================================
	// register indices (byte address on the bus is four times the index)
	localparam logic [7:0] SSER_IDX_PART_ID = 8'h00;
	localparam logic [7:0] SSER_IDX_ERROR = 8'h02;
	localparam logic [7:0] SSER_IDX_STATUS = 8'h03;
	localparam logic [7:0] SSER_IDX_AUX_X_LO = 8'h0A;
	localparam logic [7:0] SSER_IDX_AUX_X_HI = 8'h0B;
	localparam logic [7:0] SSER_IDX_AUX_Y_LO = 8'h0C;
	localparam logic [7:0] SSER_IDX_AUX_Y_HI = 8'h0D;
	localparam logic [7:0] SSER_IDX_AUX_Z_LO = 8'h0E;
	localparam logic [7:0] SSER_IDX_AUX_Z_HI = 8'h0F;
	localparam logic [7:0] SSER_IDX_AUX_R_LO = 8'h10;
	localparam logic [7:0] SSER_IDX_AUX_R_HI = 8'h11;
	localparam logic [7:0] SSER_IDX_ACC_FIRST = 8'h12;
	localparam logic [7:0] SSER_IDX_ACC_LAST = 8'h17;

	// ============================================================
	// error_report field positions
	localparam int SSER_ERR_FATAL_BIT = 0;
	localparam int SSER_ERR_CMD_BIT = 1;
	localparam int SSER_ERR_CODE_LSB = 2;
	localparam int SSER_ERR_CODE_MSB = 4;
	localparam int SSER_ERR_FIFO_BIT = 6;
	localparam int SSER_ERR_AUX_BIT = 7;

	// persistent error codes
	localparam logic [2:0] SSER_CODE_NONE = 3'h0;
	localparam logic [2:0] SSER_CODE_ACCEL_CONFIG_REGISTER = 3'h1;

	// ============================================================
	// status_flags field positions
	localparam int SSER_ST_MAN_OP_BIT = 2;
	localparam int SSER_ST_CMD_RDY_BIT = 4;
	localparam int SSER_ST_DRDY_AUX_BIT = 5;
	localparam int SSER_ST_DRDY_ACC_BIT = 7;

	// ============================================================
	// reset values
	localparam logic [7:0] SSER_ERROR_RESET = 8'h00;
	localparam logic [7:0] SSER_STATUS_RESET = 8'h10;
	localparam logic [15:0] SSER_AUX_RESET = 16'h0000;
	localparam logic [31:0] SSER_RDATA_RESET = 32'h0000_0000;

	// ============================================================
	// bus slave states
	typedef enum logic [1:0] {
		SSER_IDLE = 2'b01,
		SSER_ACCESS = 2'b10
	} sser_bus_e;

endpackage

// ### hw/sser_regs.sv
// status, error and auxiliary-sample register bank behind an APB slave
// Functional notes
// - fixed 8-bit identification code at index zero
// - fatal error sticks until power or soft reset
// - command failure sets error bit one
// - 3-bit persistent error code, one is config
// - discarded buffer data sets bit six, read clears
// - auxiliary master error sets bit seven, read clears
// - command ready low while busy, resets high
// - accel ready set on sample, cleared by read
// - aux ready set on sample, cleared by read
// - manual auxiliary operation busy shown in bit two
// - aux x/y/z 16-bit pairs, low byte first
// - aux resistance low byte, high byte next
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module sser_regs
	import sser_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter logic [7:0] PART_ID = 8'h5C // arbitrary value, replace per product
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// error events
	input wire logic i_soft_reset,
	input wire logic i_boot_fail,
	input wire logic i_cmd_fail,
	input wire logic i_accel_config_register_invalid,
	input wire logic i_buffer_discard,
	input wire logic i_aux_master_error,
	// status sources
	input wire logic i_cmd_busy,
	input wire logic i_secondary_manual_busy,
	input wire logic i_accel_sample_new,
	input wire logic i_aux_sample_new,
	input wire logic [15:0] i_aux_x,
	input wire logic [15:0] i_aux_y,
	input wire logic [15:0] i_aux_z,
	input wire logic [15:0] i_aux_r,
	// status mirror
	output logic o_cmd_ready
);

	// ============================================================
	// elaboration check
	if (ADDR_W < 7) begin : g_addr_narrow
		$error("sser_regs: ADDR_W must reach byte address 0x5C");
	end
	if (ADDR_W > 32) begin : g_addr_wide
		$error("sser_regs: ADDR_W above 32 is not supported");
	end

	// ============================================================
	// decode helpers
	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
		logic [31:0] wide;
		wide = 32'(addr);
		return wide[9:2];
	endfunction

	function automatic logic index_mapped(input logic [ADDR_W-1:0] addr);
		logic [31:0] wide;
		logic [7:0] idx;
		wide = 32'(addr);
		idx = wide[9:2];
		if (wide[1:0] != 2'h0 || wide[31:10] != 22'h0) return 1'b0;
		return idx == SSER_IDX_PART_ID || idx == SSER_IDX_ERROR || idx == SSER_IDX_STATUS
			|| (idx >= SSER_IDX_AUX_X_LO && idx <= SSER_IDX_ACC_LAST);
	endfunction

	function automatic logic is_aux_data(input logic [7:0] idx);
		return idx >= SSER_IDX_AUX_X_LO && idx <= SSER_IDX_AUX_R_HI;
	endfunction

	function automatic logic is_accel_data(input logic [7:0] idx);
		return idx >= SSER_IDX_ACC_FIRST && idx <= SSER_IDX_ACC_LAST;
	endfunction

	// ============================================================
	// bus state and transfer strobes
	sser_bus_e bus_state;
	logic setup_phase;
	logic done;
	logic done_read;
	logic [7:0] done_idx;

	assign setup_phase = i_psel && !i_penable;
	assign done = i_psel && i_penable && o_pready && bus_state == SSER_ACCESS;
	assign done_read = done && !i_pwrite && !o_pslverr;
	assign done_idx = reg_index(i_paddr);

	// ============================================================
	// register state
	logic fatal_err;
	logic [2:0] error_code;
	logic [2:0] sticky_set;
	logic [2:0] sticky_clear;
	logic [2:0] sticky_flag; // {aux_err, fifo_err, cmd_err}
	logic [1:0] drdy_set;
	logic [1:0] drdy_clear;
	logic [1:0] drdy_flag; // {acc, aux}
	logic cmd_rdy;
	logic man_op;
	logic [3:0][15:0] aux_in;
	logic [3:0][15:0] aux_word;
	logic [7:0] error_byte;
	logic [7:0] status_byte;
	logic err_read;

	// fatal flag: only reset clears it, reads never do
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fatal_err <= SSER_ERROR_RESET[SSER_ERR_FATAL_BIT];
		end else if (i_boot_fail) begin
			fatal_err <= 1'b1;
		end else if (i_soft_reset) begin
			fatal_err <= 1'b0;
		end
	end

	// persistent code follows the live configuration check
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			error_code <= SSER_CODE_NONE;
		end else begin
			error_code <= i_accel_config_register_invalid ? SSER_CODE_ACCEL_CONFIG_REGISTER
				: SSER_CODE_NONE;
		end
	end

	// clear only bits that the completed read actually returned as set
	assign err_read = done_read && done_idx == SSER_IDX_ERROR;
	assign sticky_set = {i_aux_master_error, i_buffer_discard, i_cmd_fail};
	assign sticky_clear = {
		err_read && o_prdata[SSER_ERR_AUX_BIT],
		err_read && o_prdata[SSER_ERR_FIFO_BIT],
		err_read && o_prdata[SSER_ERR_CMD_BIT]
	};

	sser_flag #(
		.WIDTH(3)
	) u_err_flags (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_set(sticky_set),
		.i_clear(sticky_clear),
		.o_flag(sticky_flag)
	);

	// data-ready flags cleared by any read of the matching data bytes
	assign drdy_set = {i_accel_sample_new, i_aux_sample_new};
	assign drdy_clear = {
		done_read && is_accel_data(done_idx),
		done_read && is_aux_data(done_idx)
	};

	sser_flag #(
		.WIDTH(2)
	) u_drdy_flags (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_set(drdy_set),
		.i_clear(drdy_clear),
		.o_flag(drdy_flag)
	);

	// command-ready and manual-operation levels, registered once
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_rdy <= SSER_STATUS_RESET[SSER_ST_CMD_RDY_BIT];
			man_op <= SSER_STATUS_RESET[SSER_ST_MAN_OP_BIT];
		end else begin
			cmd_rdy <= !i_cmd_busy;
			man_op <= i_secondary_manual_busy;
		end
	end

	// mirror output kept as its own flop so the port stays registered
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cmd_ready <= SSER_STATUS_RESET[SSER_ST_CMD_RDY_BIT];
		end else begin
			o_cmd_ready <= !i_cmd_busy;
		end
	end

	// auxiliary samples; a host reading a pair across a load may see a torn word
	assign aux_in = {i_aux_r, i_aux_z, i_aux_y, i_aux_x};

	sser_aux_hold #(
		.SAMPLE_W(16),
		.CHANNELS(4)
	) u_aux_hold (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_load(i_aux_sample_new),
		.i_sample(aux_in),
		.o_sample(aux_word)
	);

	// ============================================================
	// read image of the two flag registers, reserved bits zero
	always_comb begin
		error_byte = 8'h00;
		error_byte[SSER_ERR_FATAL_BIT] = fatal_err;
		error_byte[SSER_ERR_CMD_BIT] = sticky_flag[0];
		error_byte[SSER_ERR_CODE_MSB:SSER_ERR_CODE_LSB] = error_code;
		error_byte[SSER_ERR_FIFO_BIT] = sticky_flag[1];
		error_byte[SSER_ERR_AUX_BIT] = sticky_flag[2];
		status_byte = 8'h00;
		status_byte[SSER_ST_MAN_OP_BIT] = man_op;
		status_byte[SSER_ST_CMD_RDY_BIT] = cmd_rdy;
		status_byte[SSER_ST_DRDY_AUX_BIT] = drdy_flag[0];
		status_byte[SSER_ST_DRDY_ACC_BIT] = drdy_flag[1];
	end

	// read multiplexer; accel bytes live elsewhere and read as zero here
	function automatic logic [7:0] read_byte(input logic [7:0] idx);
		unique case (idx)
			SSER_IDX_PART_ID: return PART_ID;
			SSER_IDX_ERROR: return error_byte;
			SSER_IDX_STATUS: return status_byte;
			SSER_IDX_AUX_X_LO: return aux_word[0][7:0];
			SSER_IDX_AUX_X_HI: return aux_word[0][15:8];
			SSER_IDX_AUX_Y_LO: return aux_word[1][7:0];
			SSER_IDX_AUX_Y_HI: return aux_word[1][15:8];
			SSER_IDX_AUX_Z_LO: return aux_word[2][7:0];
			SSER_IDX_AUX_Z_HI: return aux_word[2][15:8];
			SSER_IDX_AUX_R_LO: return aux_word[3][7:0];
			SSER_IDX_AUX_R_HI: return aux_word[3][15:8];
			default: return 8'h00;
		endcase
	endfunction

	// ============================================================
	// apb slave: answer in the first access cycle, no wait states
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus_state <= SSER_IDLE;
		end else begin
			unique case (bus_state)
				SSER_IDLE: begin
					if (setup_phase) bus_state <= SSER_ACCESS;
				end
				SSER_ACCESS: begin
					if (done) bus_state <= SSER_IDLE;
				end
				default: bus_state <= SSER_IDLE;
			endcase
		end
	end

	// ready raised for one access cycle; data latched at setup
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= SSER_RDATA_RESET;
		end else if (setup_phase && bus_state == SSER_IDLE) begin
			o_pready <= 1'b1;
			o_pslverr <= !index_mapped(i_paddr);
			// writes are answered but change nothing
			o_prdata <= (i_pwrite || !index_mapped(i_paddr)) ? SSER_RDATA_RESET
				: {24'h000000, read_byte(reg_index(i_paddr))};
		end else if (done) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

	// ============================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	AST_ID_READ: assert property (
		setup_phase && !i_pwrite && reg_index(i_paddr) == SSER_IDX_PART_ID
			&& index_mapped(i_paddr) && bus_state == SSER_IDLE
		|=> o_pready && o_prdata == {24'h000000, PART_ID})
		else $error("identification read returned wrong code");

	AST_FATAL_STICKS: assert property (
		fatal_err && !i_soft_reset |=> fatal_err)
		else $error("fatal flag dropped without soft reset");

	AST_CMD_ERR_SET: assert property (
		i_cmd_fail |=> error_byte[SSER_ERR_CMD_BIT])
		else $error("command failure not recorded");

	AST_CODE_TRACK: assert property (
		error_byte[SSER_ERR_CODE_MSB:SSER_ERR_CODE_LSB]
			== ($past(i_accel_config_register_invalid) ? SSER_CODE_ACCEL_CONFIG_REGISTER : SSER_CODE_NONE))
		else $error("persistent code does not follow config check");

	AST_FIFO_CLEAR: assert property (
		err_read && o_prdata[SSER_ERR_FIFO_BIT] && !i_buffer_discard
		|=> !error_byte[SSER_ERR_FIFO_BIT])
		else $error("buffer discard flag survived its read");

	AST_AUX_ERR_HOLD: assert property (
		i_aux_master_error ##1 !err_read [*2] |=> error_byte[SSER_ERR_AUX_BIT])
		else $error("aux master error lost before any read");

	AST_CMD_READY: assert property (
		$fell(i_cmd_busy) |=> status_byte[SSER_ST_CMD_RDY_BIT] && o_cmd_ready)
		else $error("command ready not restored after busy");

	AST_ACC_CLEAR: assert property (
		done_read && is_accel_data(done_idx) && !i_accel_sample_new
		|=> !status_byte[SSER_ST_DRDY_ACC_BIT])
		else $error("accel ready not cleared by data read");

	AST_AUX_CLEAR: assert property (
		done_read && is_aux_data(done_idx) && !i_aux_sample_new
		|=> !status_byte[SSER_ST_DRDY_AUX_BIT])
		else $error("aux ready not cleared by data read");

	AST_AUX_READY: assert property (
		i_aux_sample_new |=> status_byte[SSER_ST_DRDY_AUX_BIT]
			&& aux_word[0] == $past(i_aux_x))
		else $error("aux sample not flagged or not stored");

	AST_MAN_OP: assert property (
		status_byte[SSER_ST_MAN_OP_BIT] == $past(i_secondary_manual_busy))
		else $error("manual operation bit does not follow busy");

	AST_RESERVED_ZERO: assert property (
		o_pready && !i_pwrite && i_psel
		|-> o_prdata[31:8] == 24'h000000 && !(reg_index(i_paddr) == SSER_IDX_STATUS
			&& (o_prdata[6] || o_prdata[3] || o_prdata[1] || o_prdata[0]))
			&& !(reg_index(i_paddr) == SSER_IDX_ERROR && o_prdata[5]))
		else $error("reserved bits read non-zero");

	AST_REFUSED_ZERO: assert property (
		setup_phase && bus_state == SSER_IDLE && !index_mapped(i_paddr)
		|=> o_pslverr && o_prdata == SSER_RDATA_RESET)
		else $error("refused access not flagged or returned data");

	AST_READY_PULSE: assert property (
		setup_phase && bus_state == SSER_IDLE |=> o_pready ##1 !o_pready)
		else $error("apb ready not a single access cycle");

endmodule // sser_regs
